// *** issue_stage.sv ***
// issue stage model: random operations toward the datapath
`timescale 1ns/1ps
`include "simd_map.vh"
module issue_stage (
  input wire clk,
  input wire en,
  input wire bad,
  output reg op_valid,
  output reg [`OP_W-1:0] opcode,
  output reg cond_pass,
  output reg [`REG_IDX_W-1:0] dest_index,
  output reg [31:0] first_source,
  output reg [31:0] second_source,
  output reg [4:0] shift_amount,
  output reg [1:0] rotate_sel
);
  // legal register numbers only: 13 is moved to 14, 15 never drawn
  function automatic [3:0] pick_dest(input int unsigned r);
    pick_dest = (r == 13) ? 4'hE : 4'(r);
  endfunction
  // bad mode opens every opcode and register number, for the refusal path
  always @(posedge clk) begin
    op_valid <= en && ($urandom % 8 != 0);
    opcode <= bad ? 5'($urandom) : 5'($urandom % 18);
    dest_index <= bad ? 4'($urandom) : pick_dest($urandom % 14);
    cond_pass <= ($urandom % 4 != 0);
    first_source <= $urandom;
    second_source <= $urandom;
    // zero shift is weighted up: it is the no-shift and the full-shift case
    shift_amount <= ($urandom % 4 == 0) ? 5'h00 : 5'($urandom);
    rotate_sel <= 2'($urandom);
  end
endmodule // issue_stage

// *** sat_lane.v ***
// one unsigned saturating add or subtract lane of parameterised width
`timescale 1ns/1ps
module sat_lane #(
  parameter W = 8
) (
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  input wire sub,
  output reg [W-1:0] y
);
  // one extra bit catches carry-out or borrow of this lane only
  wire [W:0] sum = {1'b0, a} + {1'b0, b};
  wire [W:0] dif = {1'b0, a} - {1'b0, b};

  always @* begin
    if (sub) begin
      y = dif[W] ? {W{1'b0}} : dif[W-1:0];
    end else begin
      y = sum[W] ? {W{1'b1}} : sum[W-1:0];
    end
  end
endmodule // sat_lane

// *** simd_map.vh ***
// opcode encodings and fixed constants for the lane-wise datapath slice
`ifndef SIMD_MAP_VH
`define SIMD_MAP_VH

`define OP_W 5
`define OP_USAT_ADD_DUAL_HALF 5'h00
`define OP_USAT_ADD_QUAD_BYTE 5'h01
`define OP_USAT_SUB_DUAL_HALF 5'h02
`define OP_USAT_SUB_QUAD_BYTE 5'h03
`define OP_PACK_LOW_HIGH_SHL 5'h04
`define OP_PACK_HIGH_LOW_SAR 5'h05
`define OP_SIGN_WIDEN_BYTE 5'h06
`define OP_ZERO_WIDEN_BYTE 5'h07
`define OP_SIGN_WIDEN_HALF 5'h08
`define OP_ZERO_WIDEN_HALF 5'h09
`define OP_SIGN_WIDEN_TWO_BYTES 5'h0A
`define OP_ZERO_WIDEN_TWO_BYTES 5'h0B
`define OP_SIGN_WIDEN_BYTE_ACCUM 5'h0C
`define OP_ZERO_WIDEN_BYTE_ACCUM 5'h0D
`define OP_SIGN_WIDEN_HALF_ACCUM 5'h0E
`define OP_ZERO_WIDEN_HALF_ACCUM 5'h0F
`define OP_SIGN_WIDEN_PAIR_ACCUM 5'h10
`define OP_ZERO_WIDEN_PAIR_ACCUM 5'h11

`define ROT_NONE 2'h0
`define ROT_8 2'h1
`define ROT_16 2'h2
`define ROT_24 2'h3

`define REG_IDX_W 4
`define REG_STACK_PTR 4'hD
`define REG_PROG_CNT 4'hF

`define SAR_FULL_SHIFT 6'h20
`define RESULT_RESET 32'h00000000

`endif

// *** simd_sat_pack_extend_unit.v ***
// lane-wise saturating, pack and extend datapath with one result register
`timescale 1ns/1ps
`include "simd_map.vh"

// Operation
// - dual halfword add, clamp each to 65535
// - quad byte add, clamp each to 255
// - dual halfword subtract, negative lanes become zero
// - quad byte subtract, clamp into 0..255
// - saturating ops never touch condition flags
// - pack low/high: low half, shifted-left top
// - pack high/low: top half, arithmetic-shifted bottom
// - pack: flags untouched, no SP/PC destination
// - extends rotate source right by 0/8/16/24
// - byte widen: bits 7:0 to 32 bits
// - half widen: bits 15:0 to 32 bits
// - two bytes widen into two halfwords
// - single accumulate adds full first source word
// - pair accumulate adds per halfword lane
// - extend ops never touch condition flags
// - failed condition leaves destination unwritten
module simd_sat_pack_extend_unit (
  input wire clk,
  input wire nrst,
  input wire op_valid,
  input wire [`OP_W-1:0] opcode,
  input wire cond_pass,
  input wire [`REG_IDX_W-1:0] dest_index,
  input wire [31:0] first_source,
  input wire [31:0] second_source,
  input wire [4:0] shift_amount,
  input wire [1:0] rotate_sel,
  output reg [31:0] result,
  output reg result_write,
  output reg [`REG_IDX_W-1:0] result_dest,
  output reg flags_write,
  output reg illegal_op
);
  reg rst_meta;
  reg rst_n_sync;

  // release of reset is resynchronised; assertion stays asynchronous
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  function [31:0] rotr;
    input [31:0] x;
    input [1:0] sel;
    begin
      case (sel)
        `ROT_8: rotr = {x[7:0], x[31:8]};
        `ROT_16: rotr = {x[15:0], x[31:16]};
        `ROT_24: rotr = {x[23:0], x[31:24]};
        default: rotr = x;
      endcase
    end
  endfunction

  // byte to halfword widening, used for both lanes of the pair forms
  function [15:0] widen8;
    input [7:0] x;
    input sgn;
    begin
      widen8 = {{8{sgn & x[7]}}, x};
    end
  endfunction

  // sign-extending members of the widen and widen-accumulate groups
  function is_signed_widen;
    input [`OP_W-1:0] op;
    begin
      case (op)
        `OP_SIGN_WIDEN_BYTE, `OP_SIGN_WIDEN_HALF, `OP_SIGN_WIDEN_TWO_BYTES,
        `OP_SIGN_WIDEN_BYTE_ACCUM, `OP_SIGN_WIDEN_HALF_ACCUM,
        `OP_SIGN_WIDEN_PAIR_ACCUM: begin
          is_signed_widen = 1'b1;
        end
        default: begin
          is_signed_widen = 1'b0;
        end
      endcase
    end
  endfunction

  // single-lane widens that keep only the low byte of the rotated word
  function is_byte_widen;
    input [`OP_W-1:0] op;
    begin
      case (op)
        `OP_SIGN_WIDEN_BYTE, `OP_ZERO_WIDEN_BYTE,
        `OP_SIGN_WIDEN_BYTE_ACCUM, `OP_ZERO_WIDEN_BYTE_ACCUM: begin
          is_byte_widen = 1'b1;
        end
        default: begin
          is_byte_widen = 1'b0;
        end
      endcase
    end
  endfunction

  wire is_sub = (opcode == `OP_USAT_SUB_DUAL_HALF) || (opcode == `OP_USAT_SUB_QUAD_BYTE);

  wire [31:0] byte_sat;
  wire [31:0] half_sat;

  // each lane instance sees only its own bits, so nothing carries across
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_byte
      sat_lane #(.W(8)) u_lane (
        .a(first_source[8*i+7:8*i]),
        .b(second_source[8*i+7:8*i]),
        .sub(is_sub),
        .y(byte_sat[8*i+7:8*i])
      );
    end
    for (i = 0; i < 2; i = i + 1) begin : g_half
      sat_lane #(.W(16)) u_lane (
        .a(first_source[16*i+15:16*i]),
        .b(second_source[16*i+15:16*i]),
        .sub(is_sub),
        .y(half_sat[16*i+15:16*i])
      );
    end
  endgenerate

  wire [31:0] shl_val = second_source << shift_amount;
  // zero shift field stands for a full 32-bit arithmetic shift
  wire [5:0] sar_amt = (shift_amount == 5'h00) ? `SAR_FULL_SHIFT : {1'b0, shift_amount};
  wire [31:0] sar_val = $signed(second_source) >>> sar_amt;

  // only the extend groups look at the rotated word
  wire [31:0] rot_val = rotr(second_source, rotate_sel);

  reg [31:0] next_result;
  reg op_known;
  reg sgn;
  reg [31:0] ext_word;
  reg [15:0] ext_lo;
  reg [15:0] ext_hi;

  always @* begin
    next_result = `RESULT_RESET;
    op_known = 1'b1;
    sgn = 1'b0;
    ext_word = 32'h00000000;
    ext_lo = 16'h0000;
    ext_hi = 16'h0000;
    sgn = is_signed_widen(opcode);
    ext_lo = widen8(rot_val[7:0], sgn);
    ext_hi = widen8(rot_val[23:16], sgn);
    if (is_byte_widen(opcode)) begin
      ext_word = {{24{sgn & rot_val[7]}}, rot_val[7:0]};
    end else begin
      ext_word = {{16{sgn & rot_val[15]}}, rot_val[15:0]};
    end
    case (opcode)
      `OP_USAT_ADD_DUAL_HALF, `OP_USAT_SUB_DUAL_HALF: begin
        next_result = half_sat;
      end
      `OP_USAT_ADD_QUAD_BYTE, `OP_USAT_SUB_QUAD_BYTE: begin
        next_result = byte_sat;
      end
      `OP_PACK_LOW_HIGH_SHL: begin
        next_result = {shl_val[31:16], first_source[15:0]};
      end
      `OP_PACK_HIGH_LOW_SAR: begin
        next_result = {first_source[31:16], sar_val[15:0]};
      end
      `OP_SIGN_WIDEN_BYTE, `OP_ZERO_WIDEN_BYTE,
      `OP_SIGN_WIDEN_HALF, `OP_ZERO_WIDEN_HALF: begin
        next_result = ext_word;
      end
      `OP_SIGN_WIDEN_TWO_BYTES, `OP_ZERO_WIDEN_TWO_BYTES: begin
        next_result = {ext_hi, ext_lo};
      end
      `OP_SIGN_WIDEN_BYTE_ACCUM, `OP_ZERO_WIDEN_BYTE_ACCUM,
      `OP_SIGN_WIDEN_HALF_ACCUM, `OP_ZERO_WIDEN_HALF_ACCUM: begin
        next_result = first_source + ext_word;
      end
      `OP_SIGN_WIDEN_PAIR_ACCUM, `OP_ZERO_WIDEN_PAIR_ACCUM: begin
        // halves added apart so the low carry is dropped
        next_result = {first_source[31:16] + ext_hi,
                       first_source[15:0] + ext_lo};
      end
      default: begin
        // unknown codes fall here and are reported as illegal
        op_known = 1'b0;
      end
    endcase
  end

  // protection against a bad issue; the issuer is expected never to do this
  wire bad_dest = (dest_index == `REG_STACK_PTR) ||
                  (dest_index == `REG_PROG_CNT);
  wire next_illegal = op_valid && (!op_known || bad_dest);
  wire next_write = op_valid && cond_pass && op_known && !bad_dest;

  always @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      result <= `RESULT_RESET;
      result_write <= 1'b0;
      result_dest <= {`REG_IDX_W{1'b0}};
      flags_write <= 1'b0;
      illegal_op <= 1'b0;
    end else begin
      result_write <= next_write;
      illegal_op <= next_illegal;
      // no operation of this unit updates the condition flags
      flags_write <= 1'b0;
      // result held when nothing is written, saving toggles
      if (next_write) begin
        result <= next_result;
        result_dest <= dest_index;
      end
    end
  end
endmodule // simd_sat_pack_extend_unit

// *** simd_sat_pack_extend_unit_chk.sv ***
// port checker for the lane-wise datapath
`timescale 1ns/1ps
`include "simd_map.vh"
module simd_sat_pack_extend_unit_chk (
  input wire clk,
  input wire nrst,
  input wire op_valid,
  input wire [`OP_W-1:0] opcode,
  input wire cond_pass,
  input wire [`REG_IDX_W-1:0] dest_index,
  input wire [31:0] first_source,
  input wire [31:0] second_source,
  input wire [4:0] shift_amount,
  input wire [1:0] rotate_sel,
  input wire [31:0] result,
  input wire result_write,
  input wire [`REG_IDX_W-1:0] result_dest,
  input wire flags_write,
  input wire illegal_op
);
  wire lg = op_valid && opcode <= 5'h11 && dest_index != 4'hD && dest_index != 4'hF;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  flags_never_a: assert property (!flags_write) else $error("flags written");
  write_on_pass_a: assert property (lg && cond_pass |=> result_write)
    else $error("passed op not written");
  no_write_fail_a: assert property (op_valid && !cond_pass |=> !result_write)
    else $error("failed condition wrote");
  sp_refused_a: assert property (op_valid && dest_index == 4'hD
    |=> illegal_op && !result_write)
    else $error("stack pointer destination taken");
  result_hold_a: assert property (!result_write |-> $stable(result))
    else $error("result moved without write");
  dest_follow_a: assert property (lg && cond_pass
    |=> result_dest == $past(dest_index))
    else $error("wrong destination");
  zero_byte_a: assert property (lg && cond_pass && opcode == `OP_ZERO_WIDEN_BYTE
    && rotate_sel == 2'h0 |=> result == {24'h000000, $past(second_source[7:0])})
    else $error("byte widen wrong");
  pack_plain_a: assert property (lg && cond_pass && opcode == `OP_PACK_LOW_HIGH_SHL
    && shift_amount == 5'h00 |=> result == {$past(second_source[31:16]),
    $past(first_source[15:0])}) else $error("pack wrong");
endmodule // simd_sat_pack_extend_unit_chk

// *** simd_sat_pack_extend_unit_tb.sv ***
// self-checking bench: random issue stream against a lane model
`timescale 1ns/1ps
module simd_sat_pack_extend_unit_tb;
  reg clk = 1'b0, nrst = 1'b0, en = 1'b0, bad = 1'b0;
  wire op_valid, cond_pass, result_write, flags_write, illegal_op;
  wire [4:0] opcode, shift_amount;
  wire [3:0] dest_index, result_dest;
  wire [31:0] first_source, second_source, result;
  wire [1:0] rotate_sel;
  int bad_count = 0, comparisons = 0, i;
  logic [31:0] er = 0;
  logic [3:0] ed = 0;
  logic ew = 0, ei = 0, lg;
  initial forever #50 clk = ~clk;
  issue_stage u_issue_stage (.clk, .en, .bad, .op_valid, .opcode, .cond_pass, .dest_index,
    .first_source, .second_source, .shift_amount, .rotate_sel);
  simd_sat_pack_extend_unit u_simd_sat_pack_extend_unit (.clk, .nrst, .op_valid, .opcode,
    .cond_pass, .dest_index, .first_source, .second_source, .shift_amount, .rotate_sel,
    .result, .result_write, .result_dest, .flags_write, .illegal_op);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] f(logic [4:0] o, logic [31:0] a, b, logic [4:0] s,
    logic [1:0] r);
    logic [31:0] y, t, e;
    logic [15:0] lo, hi;
    int n, w, m, x, z, v;
    y = 0;
    t = 32'({b, b} >> (8 * r));
    lo = !o[0] ? {{8{t[7]}}, t[7:0]} : {8'h00, t[7:0]};
    hi = !o[0] ? {{8{t[23]}}, t[23:16]} : {8'h00, t[23:16]};
    if (o == 6 || o == 7 || o == 12 || o == 13) e = !o[0] ? {{24{t[7]}}, t[7:0]} : t[7:0];
    else e = !o[0] ? {{16{t[15]}}, t[15:0]} : t[15:0];
    // lanes held as ints so an overflow is visible before the clamp
    if (o < 4) begin
      w = o[0] ? 8 : 16;
      m = (1 << w) - 1;
      for (n = 0; n < 32; n += w) begin
        x = (a >> n) & m;
        z = (b >> n) & m;
        v = o[1] ? x - z : x + z;
        v = v < 0 ? 0 : (v > m ? m : v);
        y = y | (32'(v) << n);
      end
    end else if (o == 4) begin
      t = b << s;
      y = {t[31:16], a[15:0]};
    end
    else if (o == 5) begin
      t = $signed(b) >>> (s == 0 ? 32 : s);
      y = {a[31:16], t[15:0]};
    end else if (o == 10 || o == 11) y = {hi, lo};
    else if (o > 15) y = {a[31:16] + hi, a[15:0] + lo};
    else if (o > 11) y = a + e;
    else y = e;
    return y;
  endfunction
  initial begin
    #(4000 * 100);
    bad_count++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'hc4d8b6b0));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    en <= 1'b1;
    for (i = 0; i < 3000; i++) begin
      // sampled mid-cycle, well clear of the edge that launches the outputs
      @(negedge clk);
      if (i == 2000) bad <= 1'b1;
      check(result_write, ew);
      check(illegal_op, ei);
      check(flags_write, 0);
      check(result, er);
      check(result_dest, ed);
      lg = op_valid && opcode <= 5'h11 && dest_index != 4'hD && dest_index != 4'hF;
      ew = lg && cond_pass;
      ei = op_valid && !lg;
      if (ew) begin
        er = f(opcode, first_source, second_source, shift_amount, rotate_sel);
        ed = dest_index;
      end
    end
    give_verdict;
  end
endmodule // simd_sat_pack_extend_unit_tb

bind simd_sat_pack_extend_unit simd_sat_pack_extend_unit_chk u_chk (.clk(clk), .nrst(nrst),
  .op_valid(op_valid), .opcode(opcode), .cond_pass(cond_pass), .dest_index(dest_index),
  .first_source(first_source), .second_source(second_source), .shift_amount(shift_amount),
  .rotate_sel(rotate_sel), .result(result), .result_write(result_write),
  .result_dest(result_dest), .flags_write(flags_write), .illegal_op(illegal_op));
